// ===== include/led_dim_defines.vh
// Purpose: constants for the led pulse dimming and pump ratio control
// Assumes: clock of 250 MHz (4 ns period)
// Notes: times kept in their printed unit, counts derived from them
`ifndef LED_DIM_DEFINES_VH
`define LED_DIM_DEFINES_VH

`define CLK_PERIOD_PS 4000
// program low time minimum, in ps (0.2 us)
`define PROG_LOW_MIN_PS 200000
// low time to shutdown, in ns (1.5 ms)
`define SHDN_LOW_NS 1500000
// mode transition filter delay, in ns (120 us)
`define FILTER_DELAY_NS 120000
// current settling time, in ns (40 us typical)
`define SETTLE_NS 40000

// cycle counts at 4 ns, sized to the counters: least time rounds up
// 50 cycles of program low time
`define PROG_LOW_MIN_CYC 20'h00032
// 375000 cycles of low time to shutdown
`define SHDN_LOW_CYC 20'h5b8d8
// 30000 cycles of filter delay
`define FILTER_DELAY_CYC 20'h07530
// 10000 cycles of current settling time
`define SETTLE_CYC 20'h02710

`define STEP_COUNT_W 5
`define STEP_COUNT_RST 5'h00
`define STEP_ZERO 5'h1f
`define RATIO_W 2
`define RATIO_1X 2'h0
`define RATIO_1P33X 2'h1
`define RATIO_1P5X 2'h2
`define RATIO_2X 2'h3
`define CNT_W 20

`endif

// ===== core/led_pulse_dim_mode_ctrl.v
// Purpose: decode the enable/dim wire and sequence the charge-pump ratio
// Assumes: all inputs synchronous to i_mclk; one clock domain
// Notes: analog current and sink drivers sit outside; this drives controls
// Notes: short low pulses are filtered rather than stored, so a host that
//    pulses too fast simply loses steps
// Notes: sufficient-for-1x outranks the shortfall indication
// Notes: settling status is a timer, not a measurement of the current
`timescale 1ns/100ps
`include "led_dim_defines.vh"

module led_pulse_dim_mode_ctrl #(
   parameter [19:0] SHDN_CYC = `SHDN_LOW_CYC,
   parameter [19:0] FILT_CYC = `FILTER_DELAY_CYC,
   parameter [19:0] SETTLE_CYC = `SETTLE_CYC
) (
   input wire i_mclk,
   input wire i_rstn,
   input wire i_ce,
   input wire i_enable_dim_wire,
   input wire i_supply_uvlo,
   input wire i_reg_insufficient,
   input wire i_sufficient_1x,
   output reg o_enabled,
   output reg [4:0] o_dim_steps,
   output reg o_current_settled,
   output reg [3:0] o_led_sink_channels_oe_n,
   output reg o_current_set_resistor_pin_oe_n,
   output reg [1:0] o_pump_ratio
);

   // minimum low time in cycles
   localparam [`CNT_W-1:0] LOW_MIN = `PROG_LOW_MIN_CYC;
   localparam [`CNT_W-1:0] CNT_ZERO = {`CNT_W{1'b0}};
   localparam [`CNT_W-1:0] CNT_ONE = {{(`CNT_W-1){1'b0}}, 1'b1};

   // wire decoder state
   reg en_q;
   reg en_d;
   reg wire_q;
   reg [`CNT_W-1:0] low_cnt_q;
   reg [`CNT_W-1:0] low_cnt_d;
   reg [`STEP_COUNT_W-1:0] steps_q;
   reg [`STEP_COUNT_W-1:0] steps_d;
   reg [`CNT_W-1:0] settle_cnt_q;
   reg [`CNT_W-1:0] settle_cnt_d;

   // pump sequencer state
   reg [`RATIO_W-1:0] ratio_q;
   reg [`RATIO_W-1:0] ratio_d;
   reg [`CNT_W-1:0] filt_cnt_q;
   reg [`CNT_W-1:0] filt_cnt_d;

   // next values of the registered outputs
   reg enabled_d;
   reg [`STEP_COUNT_W-1:0] dim_steps_d;
   reg settled_d;
   reg [3:0] sink_oe_n_d;
   reg cset_pin_oe_n_d;
   reg [`RATIO_W-1:0] pump_ratio_d;

   wire rise;
   wire low_long;
   wire low_enough;
   wire pulse_ok;
   wire shdn_now;
   wire filt_done;
   wire settling;

   assign rise = i_enable_dim_wire & ~wire_q;
   assign low_long = (low_cnt_q >= SHDN_CYC);
   assign low_enough = (low_cnt_q >= LOW_MIN);
   // a pulse counts only if its low phase reached the minimum
   assign pulse_ok = rise & en_q & low_enough;
   // undervoltage wins over everything, wire state included
   assign shdn_now = i_supply_uvlo | (low_long & ~i_enable_dim_wire);
   assign filt_done = (filt_cnt_q >= FILT_CYC - CNT_ONE);
   assign settling = (settle_cnt_q != CNT_ZERO);

   // low time restarts whenever the wire goes high, saturates at shutdown
   always @* begin
      if (i_enable_dim_wire) begin
         low_cnt_d = CNT_ZERO;
      end else if (!low_long) begin
         low_cnt_d = low_cnt_q + CNT_ONE;
      end else begin
         low_cnt_d = low_cnt_q;
      end
   end

   // shutdown outranks wake and dimming
   always @* begin
      en_d = en_q;
      steps_d = steps_q;
      settle_cnt_d = settle_cnt_q;
      if (shdn_now) begin
         en_d = 1'b0;
         steps_d = `STEP_COUNT_RST;
         // a cut settling window is dropped so a wake starts clean
         settle_cnt_d = CNT_ZERO;
      end else if (!en_q && rise) begin
         en_d = 1'b1;
         steps_d = `STEP_COUNT_RST;
         settle_cnt_d = SETTLE_CYC;
      end else if (pulse_ok) begin
         // 5-bit count wraps from 31 (zero current) back to 0 (full)
         steps_d = steps_q + 5'h01;
         settle_cnt_d = SETTLE_CYC;
      end else if (settling) begin
         settle_cnt_d = settle_cnt_q - CNT_ONE;
      end
   end

   // sufficient-for-1x outranks a shortfall, even at 1x
   always @* begin
      ratio_d = ratio_q;
      filt_cnt_d = filt_cnt_q;
      if (!en_q || shdn_now) begin
         // held at 1x while off so every wake starts unboosted
         ratio_d = `RATIO_1X;
         filt_cnt_d = CNT_ZERO;
      end else if (i_sufficient_1x) begin
         ratio_d = `RATIO_1X;
         filt_cnt_d = CNT_ZERO;
      end else if (!i_reg_insufficient || ratio_q == `RATIO_2X) begin
         // 2x is the ceiling, so the filter idles there
         filt_cnt_d = CNT_ZERO;
      end else if (filt_done) begin
         ratio_d = ratio_q + 2'h1;
         filt_cnt_d = CNT_ZERO;
      end else begin
         filt_cnt_d = filt_cnt_q + CNT_ONE;
      end
   end

   // pins follow the enable state one flop late
   always @* begin
      enabled_d = en_q;
      dim_steps_d = steps_q;
      settled_d = ~settling;
      sink_oe_n_d = {4{~en_q}};
      cset_pin_oe_n_d = ~en_q;
      pump_ratio_d = ratio_q;
   end

   // wire history freezes with everything else
   always @(posedge i_mclk) begin
      if (!i_rstn) begin
         en_q <= 1'b0;
         steps_q <= `STEP_COUNT_RST;
      end else if (i_ce) begin
         en_q <= en_d;
         steps_q <= steps_d;
      end
   end

   always @(posedge i_mclk) begin
      if (!i_rstn) begin
         wire_q <= 1'b0;
         low_cnt_q <= CNT_ZERO;
      end else if (i_ce) begin
         wire_q <= i_enable_dim_wire;
         low_cnt_q <= low_cnt_d;
      end
   end

   // settle window reloads on each wake and each accepted dim pulse
   always @(posedge i_mclk) begin
      if (!i_rstn) begin
         settle_cnt_q <= CNT_ZERO;
      end else if (i_ce) begin
         settle_cnt_q <= settle_cnt_d;
      end
   end

   // the filter count only runs while a shortfall persists
   always @(posedge i_mclk) begin
      if (!i_rstn) begin
         ratio_q <= `RATIO_1X;
         filt_cnt_q <= CNT_ZERO;
      end else if (i_ce) begin
         ratio_q <= ratio_d;
         filt_cnt_q <= filt_cnt_d;
      end
   end

   // every output is a flop so the pins never glitch
   always @(posedge i_mclk) begin
      if (!i_rstn) begin
         o_enabled <= 1'b0;
         o_dim_steps <= `STEP_COUNT_RST;
         o_current_settled <= 1'b1;
      end else if (i_ce) begin
         o_enabled <= enabled_d;
         o_dim_steps <= dim_steps_d;
         o_current_settled <= settled_d;
      end
   end

   always @(posedge i_mclk) begin
      if (!i_rstn) begin
         o_led_sink_channels_oe_n <= 4'hf;
         o_current_set_resistor_pin_oe_n <= 1'b1;
         o_pump_ratio <= `RATIO_1X;
      end else if (i_ce) begin
         o_led_sink_channels_oe_n <= sink_oe_n_d;
         o_current_set_resistor_pin_oe_n <= cset_pin_oe_n_d;
         o_pump_ratio <= pump_ratio_d;
      end
   end

endmodule // led_pulse_dim_mode_ctrl

// ===== tb/host_dim.sv
// Purpose: host model driving the enable/dim wire
// Assumes: tasks are called on a falling clock edge
// Notes: hi keeps high phases at 50 cycles, the least allowed; up holds the wire high for a given count
`timescale 1ns/100ps
module host_dim(input wire i_mclk, output reg o_wire);
initial o_wire = 1'b0;
task lo(input integer n); begin
   o_wire = 1'b0;
   repeat (n) @(negedge i_mclk);
end endtask
task hi; begin
   o_wire = 1'b1;
   repeat (50) @(negedge i_mclk);
end endtask
task up(input integer n); begin
   o_wire = 1'b1;
   repeat (n) @(negedge i_mclk);
end endtask
endmodule // host_dim

// ===== tb/led_dim_chk.sv
// Purpose: port checker for led_pulse_dim_mode_ctrl
// Assumes: undervoltage and sufficiency stay low while i_ce is low
// Notes: bound after the module
`timescale 1ns/100ps
module led_dim_chk(input wire i_mclk, input wire i_rstn, input wire i_ce,
 input wire i_supply_uvlo, input wire i_reg_insufficient,
 input wire i_sufficient_1x, input wire o_enabled, input wire [4:0] o_dim_steps,
 input wire o_current_settled, input wire [3:0] o_led_sink_channels_oe_n,
 input wire o_current_set_resistor_pin_oe_n, input wire [1:0] o_pump_ratio);
default clocking @(posedge i_mclk); endclocking
default disable iff (!i_rstn);
property p_off; !o_enabled |-> &o_led_sink_channels_oe_n &&
 o_current_set_resistor_pin_oe_n; endproperty
a_off: assert property (p_off) else $error("off leak");
property p_on; o_enabled |-> o_led_sink_channels_oe_n == 4'h0 &&
 !o_current_set_resistor_pin_oe_n; endproperty
a_on: assert property (p_on) else $error("on dark");
property p_uv; i_supply_uvlo |-> ##2 !o_enabled; endproperty
a_uv: assert property (p_uv) else $error("uv on");
property p_up; $changed(o_pump_ratio) |-> o_pump_ratio == 2'h0 ||
 o_pump_ratio == $past(o_pump_ratio) + 2'h1; endproperty
a_up: assert property (p_up) else $error("ratio jump");
property p_sf; i_sufficient_1x |-> ##2 o_pump_ratio == 2'h0; endproperty
a_sf: assert property (p_sf) else $error("no 1x");
property p_fl; o_pump_ratio > $past(o_pump_ratio) |->
 $past(i_reg_insufficient, 2); endproperty
a_fl: assert property (p_fl) else $error("bad step");
property p_st; $changed(o_dim_steps) |-> o_dim_steps == 5'h00 ||
 o_dim_steps == $past(o_dim_steps) + 5'h01; endproperty
a_st: assert property (p_st) else $error("dim jump");
property p_en; $rose(o_enabled) |-> o_dim_steps == 5'h00 &&
 o_pump_ratio == 2'h0 && !o_current_settled; endproperty
a_en: assert property (p_en) else $error("bad wake");
property p_frz; !i_ce |=> $stable(o_enabled) && $stable(o_dim_steps) &&
 $stable(o_pump_ratio); endproperty
a_frz: assert property (p_frz) else $error("thaw");
endmodule // led_dim_chk
bind led_pulse_dim_mode_ctrl led_dim_chk chk(.*);

// ===== tb/tb.sv
// Purpose: bench for led_pulse_dim_mode_ctrl
// Assumes: counts cut to 400/40/20
// Notes: i_ce is dropped once to check that the enable and dim steps freeze
`timescale 1ns/100ps
module tb;
reg clk = 0, rstn = 0, uv = 0, ins = 0, suf = 0, ce = 1;
wire w, en, st, rs;
wire [4:0] ds;
wire [3:0] oe;
wire [1:0] pr;
integer failures = 0, num_checks = 0, i;
host_dim host(.i_mclk(clk), .o_wire(w));
led_pulse_dim_mode_ctrl #(.SHDN_CYC(20'd400), .FILT_CYC(20'd40),
 .SETTLE_CYC(20'd20)) uut(.i_mclk(clk), .i_rstn(rstn), .i_ce(ce),
 .i_enable_dim_wire(w), .i_supply_uvlo(uv), .i_reg_insufficient(ins),
 .i_sufficient_1x(suf), .o_enabled(en), .o_dim_steps(ds),
 .o_current_settled(st), .o_led_sink_channels_oe_n(oe),
 .o_current_set_resistor_pin_oe_n(rs), .o_pump_ratio(pr));
initial forever #2 clk = ~clk;
task cy(input integer n); repeat (n) @(negedge clk); endtask
task chk(input [7:0] s, input [7:0] e, input [15:0] n); begin
   num_checks = num_checks + 1;
   if (s !== e) begin
      failures = failures + 1;
      $display("[ERR] %s exp %h got %h", n, e, s);
   end
end endtask
task stop_test; begin
   $display("checks %0d fails %0d", num_checks, failures);
   if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
   else $display("TESTS FAILED");
   $finish;
end endtask
task t_on; begin host.hi; chk(en, 8'h1, "en");
   chk(st, 8'h1, "st");
   chk(oe, 8'h0, "oe"); chk(rs, 8'h0, "rs"); $display("on ok"); end endtask
task t_dim; begin for (i = 1; i < 33; i = i + 1) begin host.lo(50); host.hi;
   chk(ds, i[4:0], "ds"); end
   host.lo(50); host.up(5); chk(st, 8'h0, "st");
   chk(ds, 8'h1, "ds");
   host.up(45); chk(st, 8'h1, "st");
   host.lo(40); host.hi; chk(ds, 8'h1, "ds"); $display("dim ok"); end endtask
task t_pump; begin ins = 1; cy(30); chk(pr, 8'h0, "pr");
   cy(15); chk(pr, 8'h1, "pr");
   for (i = 2; i < 5; i = i + 1) begin cy(45);
      chk(pr, (i > 3) ? 8'h3 : i[7:0], "pr"); end
   ins = 0; suf = 1; cy(3); chk(pr, 8'h0, "pr"); suf = 0; $display("pump ok"); end endtask
task t_off; begin host.lo(50); host.hi; host.lo(420); chk(en, 8'h0, "en");
   chk(oe, 8'hf, "oe"); chk(rs, 8'h1, "rs"); host.hi; chk(ds, 8'h0, "ds");
   $display("off ok"); end endtask
task t_uv; begin uv = 1; cy(3); chk(en, 8'h0, "en"); uv = 0; host.lo(50);
   host.hi; chk(en, 8'h1, "en"); $display("uv ok"); end endtask
task t_frz; begin ce = 0; host.lo(420); chk(en, 8'h1, "en");
   chk(ds, 8'h0, "ds");
   ce = 1; host.hi; chk(en, 8'h1, "en");
   $display("freeze ok"); end endtask
task t_rst; begin rstn = 0; cy(2); chk(en, 8'h0, "en");
   chk(oe, 8'hf, "oe");
   chk(st, 8'h1, "st");
   rstn = 1; cy(3); chk(en, 8'h1, "en");
   chk(ds, 8'h0, "ds");
   chk(pr, 8'h0, "pr");
   $display("reset ok"); end endtask
initial begin #100000; failures = failures + 1; stop_test; end
initial begin cy(12); rstn = 1; t_on; t_dim; t_pump; t_off; t_uv; t_frz;
   t_rst; stop_test; end
endmodule // tb
